/* File: pkg/acmr_cfg.svh */
/*
 Register offsets, reset values and timing counts of the channel mode and interrupt register bank.
 Assumes inclusion by bare name from the package and the design files.
*/
`ifndef ACMR_CFG_SVH
`define ACMR_CFG_SVH

`define ACMR_NUM_CHAN 26
`define ACMR_OFF_EI_STAT_LO 12'h000
`define ACMR_OFF_EI_STAT_HI 12'h004
`define ACMR_OFF_MODE0_LO 12'h008
`define ACMR_OFF_MODE0_HI 12'h00C
`define ACMR_OFF_MODE1_LO 12'h010
`define ACMR_OFF_MODE1_HI 12'h014
`define ACMR_OFF_IE_LO 12'h018
`define ACMR_OFF_IE_HI 12'h01C
`define ACMR_OFF_EI_EN_LO 12'h020
`define ACMR_OFF_EI_EN_HI 12'h024
`define ACMR_OFF_EI_LEAD 12'h028
`define ACMR_OFF_IRQ_STAT 12'h02C
`define ACMR_OFF_IRQ_CLR 12'h030
`define ACMR_OFF_IRQ_EN 12'h034
`define ACMR_RST_WORD 16'h0000
`define ACMR_LEAD_MAX_PERIODS 4'h8

`endif

/* File: pkg/acmr_pkg.sv */
/*
 Types shared by the channel mode and interrupt register bank.
 Assumes acmr_cfg.svh is on the include path.
*/
package acmr_pkg;
`include "acmr_cfg.svh"

    typedef enum logic [2:0] {
        ACMR_AHB_IDLE = 3'b001,
        ACMR_AHB_WR = 3'b010,
        ACMR_AHB_RD = 3'b100
    } acmr_phase_e;

    typedef struct packed {
        logic [11:0] addr;
        logic wr;
        logic rd;
    } acmr_req_s;

    typedef struct packed {
        logic [`ACMR_NUM_CHAN-1:0] input_sel_a;
        logic [`ACMR_NUM_CHAN-1:0] sign_sel;
    } acmr_mode_s;
endpackage

/* File: design/acmr_lead_cnt.sv */
/*
 Early interrupt lead timer: counts conversion clock ticks down to the early point.
 Assumes conv_start_i and core_tick_i come from logic on clk_i.
*/
`timescale 1ns/100ps
module acmr_lead_cnt
    import acmr_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [2:0] lead_code_i,
    input wire logic [3:0] conv_len_i,
    input wire logic conv_start_i,
    input wire logic core_tick_i,
    output logic early_o
);
    logic [3:0] remain_r;
    logic [3:0] remain_nxt;
    logic [3:0] lead_periods;

    // Code 0 gives one period, code 7 gives eight
    assign lead_periods = {1'b0, lead_code_i} + 4'h1;
    assign remain_nxt = conv_start_i ? conv_len_i :
                        (core_tick_i && remain_r != 4'h0) ? remain_r - 4'h1 : remain_r;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            remain_r <= 4'h0;
        else
            remain_r <= remain_nxt;
    end

    // One pulse as the remaining count reaches the lead
    assign early_o = core_tick_i && remain_r != 4'h0 && (remain_r - 4'h1) == lead_periods;
endmodule

/* File: design/acmr_regs.sv */
/*
 Per-channel input mode, interrupt enable and early interrupt status registers on AHB-Lite.
 Assumes one AHB-Lite master, single word transfers, and conversion events on clk_i.
*/
// Summary of operation
// - Channels 16-25 set bits 9:0 of the upper early status word on early interrupt.
// - Early status bit clears when software reads that channel's result buffer.
// - Bits 15:10 of upper status and enable words ignore writes, read zero.
// - Differential selector one converts a pair, zero converts single-ended.
// - Sign selector one delivers signed results, zero delivers unsigned.
// - Channel n uses bits 2(n mod 8)+1 (differential) and 2(n mod 8) (sign).
// - Mode words hold channels 0-7, 8-15, 16-23, 24-25; last word bits 15:4 zero.
// - Enable one allows common and individual interrupts from that channel.
// - Enable zero raises neither common nor individual interrupt for the channel.
// - All implemented channel bits are read-write and reset to zero.
// - Implemented channel bits depend on the channel count of the variant.
// - Early lead is one to eight conversion clock periods, code 0 to 7.
// - Early enable one allows the channel's early interrupt, zero suppresses it.
`timescale 1ns/100ps
`include "acmr_cfg.svh"
module acmr_regs
    import acmr_pkg::*;
#(
    parameter int NUM_CHAN = `ACMR_NUM_CHAN
)
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic [25:0] conv_start_i,
    input wire logic [25:0] conv_done_i,
    input wire logic [25:0] buf_read_i,
    input wire logic [3:0] conv_len_i,
    input wire logic core_tick_i,
    output logic [25:0] input_sel_a_o,
    output logic [25:0] sign_sel_o,
    output logic [25:0] chan_irq_o,
    output logic common_irq_o,
    output logic [25:0] early_irq_o,
    output logic irq_o
);
    localparam logic [25:0] CHAN_MASK = 26'((64'h1 << NUM_CHAN) - 64'h1);

    acmr_phase_e phase_r;
    acmr_phase_e phase_nxt;
    acmr_req_s req_r;
    logic [25:0] early_irq_flag_r;
    logic [25:0] early_irq_flag_nxt;
    logic [25:0] chan_irq_en_r;
    logic [25:0] early_irq_en_r;
    acmr_mode_s mode_r;
    logic [2:0] early_irq_lead_r;
    logic [1:0] irq_stat_r;
    logic [1:0] irq_stat_nxt;
    logic [1:0] irq_en_r;
    logic [25:0] early_pulse;
    logic [25:0] early_gated;
    logic [25:0] ev_gated;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic addr_take;
    logic wr_en;

    function automatic logic sel(input logic [11:0] a, input logic [11:0] off);
        sel = (a == off);
    endfunction

    // Packs channel pairs; differential at odd, sign at even
    function automatic logic [15:0] pack_mode(input acmr_mode_s m, input int base);
        logic [15:0] w;
        w = 16'h0000;
        for (int i = 0; i < 8; i++)
        begin
            if (base + i < NUM_CHAN)
            begin
                w[2*i+1] = m.input_sel_a[base+i];
                w[2*i] = m.sign_sel[base+i];
            end
        end
        pack_mode = w;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: zero wait state, always OKAY

    assign addr_take = hsel_i && hready_i && htrans_i[1];
    assign phase_nxt = !addr_take ? ACMR_AHB_IDLE : (hwrite_i ? ACMR_AHB_WR : ACMR_AHB_RD);
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign wr_en = (phase_r == ACMR_AHB_WR);
    assign wdata = hwdata_i;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            phase_r <= ACMR_AHB_IDLE;
            req_r <= '0;
        end
        else
        begin
            phase_r <= phase_nxt;
            req_r <= '{addr: haddr_i[11:0], wr: hwrite_i, rd: !hwrite_i};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Early interrupt lead timers, one per channel

    genvar g;
    generate
        for (g = 0; g < 26; g++)
        begin : g_lead
            acmr_lead_cnt u_lead (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .lead_code_i(early_irq_lead_r),
                .conv_len_i(conv_len_i),
                .conv_start_i(conv_start_i[g]),
                .core_tick_i(core_tick_i),
                .early_o(early_pulse[g])
            );
        end
    endgenerate

    assign early_gated = early_pulse & early_irq_en_r & CHAN_MASK;

    ////////////////////////////////////////////////////////////////////////
    // Configuration registers

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            chan_irq_en_r <= 26'h000_0000;
            early_irq_en_r <= 26'h000_0000;
            mode_r <= '0;
            early_irq_lead_r <= 3'h0;
            irq_en_r <= 2'h0;
        end
        else if (wr_en)
        begin
            if (sel(req_r.addr, `ACMR_OFF_IE_LO))
                chan_irq_en_r[15:0] <= wdata[15:0] & CHAN_MASK[15:0];
            if (sel(req_r.addr, `ACMR_OFF_IE_HI))
                chan_irq_en_r[25:16] <= wdata[9:0] & CHAN_MASK[25:16];
            if (sel(req_r.addr, `ACMR_OFF_EI_EN_LO))
                early_irq_en_r[15:0] <= wdata[15:0] & CHAN_MASK[15:0];
            if (sel(req_r.addr, `ACMR_OFF_EI_EN_HI))
                early_irq_en_r[25:16] <= wdata[9:0] & CHAN_MASK[25:16];
            if (sel(req_r.addr, `ACMR_OFF_EI_LEAD))
                early_irq_lead_r <= wdata[2:0];
            if (sel(req_r.addr, `ACMR_OFF_IRQ_EN))
                irq_en_r <= wdata[1:0];
            for (int i = 0; i < 8; i++)
            begin
                if (sel(req_r.addr, `ACMR_OFF_MODE0_LO))
                begin
                    mode_r.input_sel_a[i] <= wdata[2*i+1] & CHAN_MASK[i];
                    mode_r.sign_sel[i] <= wdata[2*i] & CHAN_MASK[i];
                end
                if (sel(req_r.addr, `ACMR_OFF_MODE0_HI))
                begin
                    mode_r.input_sel_a[8+i] <= wdata[2*i+1] & CHAN_MASK[8+i];
                    mode_r.sign_sel[8+i] <= wdata[2*i] & CHAN_MASK[8+i];
                end
                if (sel(req_r.addr, `ACMR_OFF_MODE1_LO))
                begin
                    mode_r.input_sel_a[16+i] <= wdata[2*i+1] & CHAN_MASK[16+i];
                    mode_r.sign_sel[16+i] <= wdata[2*i] & CHAN_MASK[16+i];
                end
            end
            // Last mode word holds two channels; a separate loop keeps every index in range
            for (int i = 0; i < 2; i++)
            begin
                if (sel(req_r.addr, `ACMR_OFF_MODE1_HI))
                begin
                    mode_r.input_sel_a[24+i] <= wdata[2*i+1] & CHAN_MASK[24+i];
                    mode_r.sign_sel[24+i] <= wdata[2*i] & CHAN_MASK[24+i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Early interrupt status and block interrupt status

    // Hardware set wins over a buffer read or software write in the same cycle
    always_comb
    begin
        early_irq_flag_nxt = early_irq_flag_r & ~buf_read_i;
        if (wr_en && sel(req_r.addr, `ACMR_OFF_EI_STAT_LO))
            early_irq_flag_nxt[15:0] = wdata[15:0];
        if (wr_en && sel(req_r.addr, `ACMR_OFF_EI_STAT_HI))
            early_irq_flag_nxt[25:16] = wdata[9:0];
        early_irq_flag_nxt = (early_irq_flag_nxt | early_gated) & CHAN_MASK;
    end

    assign ev_gated = conv_done_i & chan_irq_en_r;

    always_comb
    begin
        irq_stat_nxt = irq_stat_r;
        if (wr_en && sel(req_r.addr, `ACMR_OFF_IRQ_CLR))
            irq_stat_nxt = irq_stat_r & ~wdata[1:0];
        if (|ev_gated)
            irq_stat_nxt[0] = 1'b1;
        if (|early_gated)
            irq_stat_nxt[1] = 1'b1;
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            early_irq_flag_r <= 26'h000_0000;
            irq_stat_r <= 2'h0;
        end
        else
        begin
            early_irq_flag_r <= early_irq_flag_nxt;
            irq_stat_r <= irq_stat_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs toward the converter and interrupt controller

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            chan_irq_o <= 26'h000_0000;
            common_irq_o <= 1'b0;
            early_irq_o <= 26'h000_0000;
            hrdata_o <= 32'h0000_0000;
        end
        else
        begin
            chan_irq_o <= ev_gated & CHAN_MASK;
            common_irq_o <= |(ev_gated & CHAN_MASK);
            early_irq_o <= early_gated;
            hrdata_o <= (addr_take && !hwrite_i) ? rdata : 32'h0000_0000;
        end
    end

    assign input_sel_a_o = mode_r.input_sel_a;
    assign sign_sel_o = mode_r.sign_sel;
    assign irq_o = |(irq_stat_r & irq_en_r);

    ////////////////////////////////////////////////////////////////////////
    // Read mux, sampled in the address phase; unmapped reads as zero

    logic [11:0] ra;
    logic [15:0] mode1_hi_word;
    assign ra = haddr_i[11:0];
    // A function result cannot be part-selected directly, hence the named wire
    assign mode1_hi_word = pack_mode(mode_r, 24);
    assign rdata =
        sel(ra, `ACMR_OFF_EI_STAT_LO) ? {16'h0000, early_irq_flag_r[15:0]} :
        sel(ra, `ACMR_OFF_EI_STAT_HI) ? {22'h00_0000, early_irq_flag_r[25:16]} :
        sel(ra, `ACMR_OFF_MODE0_LO) ? {16'h0000, pack_mode(mode_r, 0)} :
        sel(ra, `ACMR_OFF_MODE0_HI) ? {16'h0000, pack_mode(mode_r, 8)} :
        sel(ra, `ACMR_OFF_MODE1_LO) ? {16'h0000, pack_mode(mode_r, 16)} :
        sel(ra, `ACMR_OFF_MODE1_HI) ? {28'h000_0000, mode1_hi_word[3:0]} :
        sel(ra, `ACMR_OFF_IE_LO) ? {16'h0000, chan_irq_en_r[15:0]} :
        sel(ra, `ACMR_OFF_IE_HI) ? {22'h00_0000, chan_irq_en_r[25:16]} :
        sel(ra, `ACMR_OFF_EI_EN_LO) ? {16'h0000, early_irq_en_r[15:0]} :
        sel(ra, `ACMR_OFF_EI_EN_HI) ? {22'h00_0000, early_irq_en_r[25:16]} :
        sel(ra, `ACMR_OFF_EI_LEAD) ? {29'h0000_0000, early_irq_lead_r} :
        sel(ra, `ACMR_OFF_IRQ_STAT) ? {30'h0000_0000, irq_stat_r} :
        sel(ra, `ACMR_OFF_IRQ_EN) ? {30'h0000_0000, irq_en_r} :
        32'h0000_0000;
endmodule

/* File: bench/acmr_regs_sva.sv */
/*
 Checker of the channel mode and interrupt register bank.
 Assumes it is bound to acmr_regs, which has a single AHB-Lite master.
*/
`timescale 1ns/100ps
module acmr_regs_sva
    import acmr_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic hready_i,
    input wire logic [31:0] hrdata_o,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic [25:0] conv_done_i,
    input wire logic [25:0] input_sel_a_o,
    input wire logic [25:0] sign_sel_o,
    input wire logic [25:0] chan_irq_o,
    input wire logic common_irq_o,
    input wire logic irq_o
);
    wire logic take_w;
    logic wr_dp_r;
    logic rd_dp_r;
    assign take_w = hsel_i & hready_i & htrans_i[1];
    // Data phase trackers, so outputs can be tied to the bus cycle behind them
    always_ff @(posedge clk_i)
    begin
        wr_dp_r <= !rst_i & take_w & hwrite_i;
        rd_dp_r <= !rst_i & take_w & !hwrite_i;
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ////////////////////////////////////////
    AST_CAUSE: assert property ((chan_irq_o & ~$past(conv_done_i)) == 26'h000_0000)
        else $error("channel irq without event");
    AST_COMMON: assert property (common_irq_o == |chan_irq_o)
        else $error("common irq differs");
    AST_HI_ZERO: assert property (hrdata_o[31:16] == 16'h0000)
        else $error("upper read bits set");
    AST_OKAY: assert property (hreadyout_o && !hresp_o)
        else $error("bus not ready or error");
    AST_RST: assert property (disable iff (1'b0) rst_i |=> !irq_o && sign_sel_o == 26'h000_0000)
        else $error("not cleared by reset");
    // A one-edge reset would look like a change, hence the past reset guard
    AST_MODE_WR: assert property (!$past(rst_i) && $changed({input_sel_a_o, sign_sel_o}) |-> $past(wr_dp_r))
        else $error("mode changed without write");
    AST_RD_STAND: assert property (hrdata_o != 32'h0000_0000 |-> rd_dp_r)
        else $error("read data outside data phase");
    AST_IRQ_FALL: assert property (!$past(rst_i) && $fell(irq_o) |-> $past(wr_dp_r))
        else $error("irq dropped without write");
endmodule

bind acmr_regs acmr_regs_sva u_sva
(
    .clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
    .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .conv_done_i(conv_done_i), .input_sel_a_o(input_sel_a_o), .sign_sel_o(sign_sel_o),
    .chan_irq_o(chan_irq_o), .common_irq_o(common_irq_o), .irq_o(irq_o)
);

/* File: bench/acmr_regs_test.sv */
/*
 Self-checking bench of the channel mode and interrupt register bank.
 Assumes acmr_pkg, the design and the bound checker are compiled first.
*/
`timescale 1ns/100ps
`include "acmr_cfg.svh"
module acmr_regs_test
    import acmr_pkg::*;
;
    logic clk_i = 1'b0, rst_i = 1'b1, hsel = 1'b0, hwrite = 1'b0, tick = 1'b0, early_seen = 1'b0;
    logic common, irq, hresp;
    wire logic hready;
    logic [1:0] htrans = 2'b00;
    logic [3:0] conv_len = 4'h0;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
    logic [25:0] done = '0, start = '0, bread = '0, sel_a, sign, chan, early;
    logic [11:0] ma;
    int errors = 0, n_checks = 0, n, b;
    logic [11:0] adr [7] = '{`ACMR_OFF_EI_STAT_HI, `ACMR_OFF_MODE0_LO, `ACMR_OFF_MODE0_HI,
        `ACMR_OFF_MODE1_LO, `ACMR_OFF_MODE1_HI, `ACMR_OFF_IE_LO, `ACMR_OFF_IE_HI};
    logic [15:0] msk [7] = '{16'h03FF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'h000F, 16'hFFFF, 16'h03FF};
    int chs [4] = '{0, 9, 23, 25};

    acmr_regs uut
    (
        .clk_i(clk_i), .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
        .hresp_o(hresp), .conv_start_i(start), .conv_done_i(done), .buf_read_i(bread),
        .conv_len_i(conv_len), .core_tick_i(tick), .input_sel_a_o(sel_a), .sign_sel_o(sign),
        .chan_irq_o(chan), .common_irq_o(common), .early_irq_o(early), .irq_o(irq)
    );

    initial
    begin
        forever #2.5 clk_i = ~clk_i;
    end

    // Early pulses last one cycle, so they are caught here
    always @(posedge clk_i)
        if (early[16] === 1'b1)
            early_seen <= 1'b1;
    ////////////////////////////////////////
    task automatic stop_test;
        if (errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t %h %h", $time, got, exp);
        end
    endtask

    task automatic wait_rdy;
        int i;
        i = 0;
        do
        begin
            @(posedge clk_i);
            i++;
        end
        while (hready !== 1'b1 && i < 64);
        if (hready !== 1'b1)
        begin
            errors++;
            stop_test();
        end
    endtask

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        haddr <= {20'h0_0000, a};
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, '0);
        chk(q, e);
    endtask

    task automatic ev(input logic [25:0] d, s, r, input logic t);
        done <= d;
        start <= s;
        bread <= r;
        tick <= t;
        @(posedge clk_i);
        done <= '0;
        start <= '0;
        bread <= '0;
        tick <= 1'b0;
        @(posedge clk_i);
    endtask
    ////////////////////////////////////////
    initial
    begin
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        for (int a = 0; a < 16; a++)
            rd(12'(a * 4), '0);
        foreach (adr[i])
        begin
            wr(adr[i], 32'hFFFF_FFFF);
            rd(adr[i], {16'h0000, msk[i]});
            wr(adr[i], '0);
        end
        foreach (chs[i])
        begin
            ma = `ACMR_OFF_MODE0_LO + 12'(4 * (chs[i] / 8));
            b = 2 * (chs[i] % 8);
            wr(ma, 32'h0000_0001 << (b + 1));
            @(posedge clk_i);
            chk({6'h00, sel_a}, 32'h0000_0001 << chs[i]);
            chk({6'h00, sign}, '0);
            wr(ma, 32'h0000_0001 << b);
            @(posedge clk_i);
            chk({6'h00, sign}, 32'h0000_0001 << chs[i]);
            chk({6'h00, sel_a}, '0);
            wr(ma, '0);
        end
        wr(`ACMR_OFF_IE_LO, 32'h0000_0001);
        wr(`ACMR_OFF_IE_HI, 32'h0000_0002);
        ev(26'h000_0002, '0, '0, 1'b0);
        chk({5'h00, common, chan}, '0);
        ev(26'h000_0001, '0, '0, 1'b0);
        chk({5'h00, common, chan}, 32'h0400_0001);
        ev(26'h002_0000, '0, '0, 1'b0);
        chk({5'h00, common, chan}, 32'h0402_0000);
        rd(`ACMR_OFF_IRQ_STAT, 32'h0000_0001);
        chk(32'(irq), '0);
        wr(`ACMR_OFF_IRQ_EN, 32'h0000_0001);
        @(posedge clk_i);
        chk(32'(irq), 32'h0000_0001);
        wr(`ACMR_OFF_IRQ_CLR, 32'h0000_0001);
        @(posedge clk_i);
        chk(32'(irq), '0);
        rd(`ACMR_OFF_IRQ_STAT, '0);
        // Only channel 16 has its early interrupt enabled; channel 17 runs alongside
        wr(`ACMR_OFF_EI_EN_HI, 32'h0000_0001);
        for (int k = 0; k < 2; k++)
        begin
            wr(`ACMR_OFF_EI_LEAD, k ? 32'h0000_0007 : '0);
            conv_len <= k ? 4'hA : 4'h4;
            ev('0, 26'h003_0000, '0, 1'b0);
            early_seen = 1'b0;
            n = 0;
            while (!early_seen && n < 12)
            begin
                ev('0, '0, '0, 1'b1);
                repeat (2) @(posedge clk_i);
                n++;
            end
            chk(32'(n), k ? 32'h0000_0002 : 32'h0000_0003);
        end
        rd(`ACMR_OFF_EI_STAT_HI, 32'h0000_0001);
        ev('0, '0, 26'h001_0000, 1'b0);
        rd(`ACMR_OFF_EI_STAT_HI, '0);
        stop_test();
    end
endmodule
